// >>> hw/sler_pkg.sv
// constants and carrier types for the serial link error summary block
// Behaviour
// - bit 7 set when disparity count hits threshold
// - bit 6 set when table-miss count hits threshold
// - bit 5 set when stray-control count hits threshold
// - bit 3 set when any usable lane alignment failed
// - bit 2 set when any usable lane checksum bad
// - bit 1 set when any usable lane frame alignment failed
// - bit 0 set when any usable lane symbol lock failed
// - select bit 7 routes disparity to sync request
// - select bit 6 routes table miss to sync
// - select bit 5 routes stray control to sync
// - enabled mismatch latches on rise, pulls irq low
// - mismatch latch cleared by writing one or by clearing the enable
// - enable low: mismatch latch inert, no irq
// - mismatch when lane 0 config differs from local
// - mismatch irq enable resets to one
// - summary read-only, zero after reset, bit 4 reserved
// - summary address write loads irq mask bits
// - per-lane counts versus 8-bit threshold, reset ones
package sler_pkg;
  // register addresses on the control port
  localparam logic [12:0] ADDR_SUMMARY = 13'h047a;
  localparam logic [12:0] ADDR_SELECT = 13'h047b;
  localparam logic [12:0] ADDR_THRESHOLD = 13'h047c;
  // field positions
  localparam int BIT_DISPARITY = 7;
  localparam int BIT_TABLE_MISS = 6;
  localparam int BIT_STRAY_CTRL = 5;
  localparam int BIT_MISMATCH = 4;
  localparam int BIT_ALIGN = 3;
  localparam int BIT_CONFIG_MISMATCH_IRQ_ENABLE = 3;
  localparam int BIT_CHECKSUM = 2;
  localparam int BIT_FRAME = 1;
  localparam int BIT_SYMBOL = 0;
  // implemented bits of each register
  localparam logic [7:0] SUMMARY_BITS = 8'hef;
  localparam logic [7:0] SELECT_BITS = 8'he0;
  // reset values
  localparam logic [7:0] RESET_MASK = 8'h00;
  localparam logic [7:0] RESET_SELECT = 8'h00;
  localparam logic RESET_CONFIG_MISMATCH_IRQ_ENABLE = 1'b1;
  localparam logic [7:0] RESET_THRESHOLD = 8'hff;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_FULL = 8'hff;
  localparam logic [7:0] COUNT_STEP = 8'h01;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // lane and configuration sizes
  localparam int MAX_LANES = 8;
  localparam int CFG_BYTES = 14;
  localparam int CFG_BITS = CFG_BYTES * 8;
  // counted error classes
  localparam int CLS_DISPARITY = 0;
  localparam int CLS_TABLE_MISS = 1;
  localparam int CLS_STRAY_CTRL = 2;
  localparam int NUM_CLASSES = 3;

  // per-lane events from the lane error monitor
  typedef struct packed {
    logic [MAX_LANES-1:0] disparity_err;
    logic [MAX_LANES-1:0] table_miss_err;
    logic [MAX_LANES-1:0] stray_control_err;
    logic [MAX_LANES-1:0] align_fail;
    logic [MAX_LANES-1:0] checksum_fail;
    logic [MAX_LANES-1:0] frame_fail;
    logic [MAX_LANES-1:0] symbol_fail;
  } sler_lane_type;

  // control port request
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [12:0] addr;
    logic [7:0] wdata;
  } sler_req_type;

  // whole state of the block
  typedef struct packed {
    logic [7:0] irq_mask;
    logic [7:0] sync_select;
    logic config_mismatch_irq_enable;
    logic config_mismatch_latch;
    logic mismatch_prev;
    logic [7:0] error_count_threshold;
    logic [MAX_LANES-1:0][NUM_CLASSES-1:0][7:0] counts;
    logic [7:0] link_error_summary;
    logic sync_request_output;
    logic irq_n;
    logic [7:0] rd_data;
    logic rd_valid;
  } sler_state_type;
endpackage

// >>> hw/sler_top.sv
// error summary, sync request selection and mismatch interrupt logic
`timescale 1ns/100ps
module sler_top import sler_pkg::*; #(
  parameter int LANES = MAX_LANES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // lane error monitor
  input wire sler_lane_type lane_events,
  input wire logic [MAX_LANES-1:0] lane_enable,
  input wire logic error_count_clear,
  // link configuration comparison
  input wire logic [CFG_BITS-1:0] rx_link_config,
  input wire logic [CFG_BITS-1:0] local_link_config,
  // control port
  input wire sler_req_type reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // device outputs
  output logic sync_request_output,
  output logic irq_n
);
  // refuse lane counts the state cannot hold
  if (LANES < 1 || LANES > MAX_LANES) begin : g_lane_check
    $error("LANES must be between 1 and MAX_LANES");
  end

  // saturating increment of one error counter
  function automatic logic [7:0] bump(input logic [7:0] cnt, input logic ev);
    bump = (ev && cnt != COUNT_FULL) ? cnt + COUNT_STEP : cnt;
  endfunction

  // true when any usable lane shows the condition
  function automatic logic any_lane(input logic [MAX_LANES-1:0] v,
                                    input logic [MAX_LANES-1:0] en);
    any_lane = |(v & en);
  endfunction

  sler_state_type state; // registered state
  sler_state_type next_state; // next value of the state
  logic [MAX_LANES-1:0] lane_use; // enabled and present lanes
  logic [NUM_CLASSES-1:0] reached; // class count reached threshold on a lane
  logic [MAX_LANES-1:0][NUM_CLASSES-1:0] lane_ev; // events by lane and class
  logic mismatch_now; // lane 0 config differs from local settings
  logic [7:0] flags; // live summary flags

  // combinational next state
  always_comb begin
    next_state = state;
    for (int l = 0; l < MAX_LANES; l++) begin
      lane_use[l] = lane_enable[l] && (l < LANES);
      lane_ev[l][CLS_DISPARITY] = lane_events.disparity_err[l];
      lane_ev[l][CLS_TABLE_MISS] = lane_events.table_miss_err[l];
      lane_ev[l][CLS_STRAY_CTRL] = lane_events.stray_control_err[l];
    end
    // count errors per lane, saturating
    reached = '0;
    for (int l = 0; l < MAX_LANES; l++) begin
      for (int c = 0; c < NUM_CLASSES; c++) begin
        if (error_count_clear) begin
          next_state.counts[l][c] = COUNT_ZERO;
        end else begin
          next_state.counts[l][c] = bump(state.counts[l][c], lane_ev[l][c] && lane_use[l]);
        end
        if (lane_use[l] && state.counts[l][c] >= state.error_count_threshold) begin
          reached[c] = 1'b1;
        end
      end
    end
    // summary flags, live view of lane conditions
    flags = READ_ZERO;
    flags[BIT_DISPARITY] = reached[CLS_DISPARITY];
    flags[BIT_TABLE_MISS] = reached[CLS_TABLE_MISS];
    flags[BIT_STRAY_CTRL] = reached[CLS_STRAY_CTRL];
    flags[BIT_ALIGN] = any_lane(lane_events.align_fail, lane_use);
    flags[BIT_CHECKSUM] = any_lane(lane_events.checksum_fail, lane_use);
    flags[BIT_FRAME] = any_lane(lane_events.frame_fail, lane_use);
    flags[BIT_SYMBOL] = any_lane(lane_events.symbol_fail, lane_use);
    next_state.link_error_summary = flags & SUMMARY_BITS;
    // selected counted classes raise the sync request
    next_state.sync_request_output =
      (state.sync_select[BIT_DISPARITY] && reached[CLS_DISPARITY]) ||
      (state.sync_select[BIT_TABLE_MISS] && reached[CLS_TABLE_MISS]) ||
      (state.sync_select[BIT_STRAY_CTRL] && reached[CLS_STRAY_CTRL]);
    // configuration mismatch detection and latch
    mismatch_now = rx_link_config != local_link_config;
    next_state.mismatch_prev = mismatch_now;
    if (reg_req.wr_en && reg_req.addr == ADDR_SELECT && reg_req.wdata[BIT_MISMATCH]) begin
      next_state.config_mismatch_latch = 1'b0;
    end
    if (state.config_mismatch_irq_enable && mismatch_now && !state.mismatch_prev) begin
      next_state.config_mismatch_latch = 1'b1;
    end
    // register writes
    if (reg_req.wr_en) begin
      case (reg_req.addr)
        ADDR_SUMMARY: begin
          next_state.irq_mask = reg_req.wdata & SUMMARY_BITS;
        end
        ADDR_SELECT: begin
          next_state.sync_select = reg_req.wdata & SELECT_BITS;
          next_state.config_mismatch_irq_enable = reg_req.wdata[BIT_CONFIG_MISMATCH_IRQ_ENABLE];
        end
        ADDR_THRESHOLD: begin
          next_state.error_count_threshold = reg_req.wdata;
        end
        default: begin
          // unmapped writes are ignored
        end
      endcase
    end
    // a disabled latch is inert; the new enable is used so that clearing the
    // enable never leaves a stale latch visible for one cycle
    if (!next_state.config_mismatch_irq_enable) begin
      next_state.config_mismatch_latch = 1'b0;
    end
    // interrupt low while any masked flag or the latch stands
    next_state.irq_n = !(|(state.link_error_summary & state.irq_mask) ||
                         (state.config_mismatch_irq_enable && state.config_mismatch_latch));
    // register reads
    next_state.rd_valid = reg_req.rd_en;
    next_state.rd_data = READ_ZERO;
    if (reg_req.rd_en) begin
      case (reg_req.addr)
        ADDR_SUMMARY: begin
          next_state.rd_data = state.link_error_summary;
        end
        ADDR_SELECT: begin
          next_state.rd_data = state.sync_select;
          next_state.rd_data[BIT_MISMATCH] = state.config_mismatch_latch;
          next_state.rd_data[BIT_CONFIG_MISMATCH_IRQ_ENABLE] = state.config_mismatch_irq_enable;
        end
        ADDR_THRESHOLD: begin
          next_state.rd_data = state.error_count_threshold;
        end
        default: begin
          next_state.rd_data = READ_ZERO;
        end
      endcase
    end
  end

  // state register with synchronous reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= '0;
      state.irq_mask <= RESET_MASK;
      state.sync_select <= RESET_SELECT;
      state.config_mismatch_irq_enable <= RESET_CONFIG_MISMATCH_IRQ_ENABLE;
      state.error_count_threshold <= RESET_THRESHOLD;
      state.link_error_summary <= READ_ZERO;
      state.irq_n <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata = state.rd_data;
  assign reg_rvalid = state.rd_valid;
  assign sync_request_output = state.sync_request_output;
  assign irq_n = state.irq_n;
endmodule // sler_top

// >>> verif/sler_lane_model.sv
// lane-side stand-in: per-lane error events and received link parameters
`timescale 1ns/100ps
module sler_lane_model import sler_pkg::*; (
  // stimulus from the bench
  input wire logic [6:0] kind,
  input wire logic cfg_bad,
  input wire logic [CFG_BITS-1:0] local_link_config,
  // toward the block
  output sler_lane_type lane_events,
  output logic [CFG_BITS-1:0] rx_link_config
);
  // kind bit j raises lane 0 of the j-th field, counted from the lowest
  always_comb begin
    lane_events = '0;
    for (int j = 0; j < 7; j++) begin
      lane_events[j*MAX_LANES] = kind[j];
    end
  end
  // a bad parameter set differs from the local one in its lowest octet
  assign rx_link_config = local_link_config ^ {{(CFG_BITS-8){1'b0}}, {8{cfg_bad}}};
endmodule // sler_lane_model

// >>> verif/sler_props.sv
// port-level assertions for the error summary block
`timescale 1ns/100ps
module sler_props import sler_pkg::*; #(parameter int LANES = MAX_LANES) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // lane side
  input wire sler_lane_type lane_events,
  input wire logic [MAX_LANES-1:0] lane_enable,
  input wire logic error_count_clear,
  input wire logic [CFG_BITS-1:0] rx_link_config,
  input wire logic [CFG_BITS-1:0] local_link_config,
  // control port and outputs
  input wire sler_req_type reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic sync_request_output,
  input wire logic irq_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // reads taken at this edge, live level failures and mismatch
  logic rd_sum, rd_sel, mism;
  logic [3:0] fails;
  assign rd_sum = reg_req.rd_en && reg_req.addr == ADDR_SUMMARY;
  assign rd_sel = reg_req.rd_en && reg_req.addr == ADDR_SELECT;
  assign mism = rx_link_config != local_link_config;
  assign fails = {|(lane_events.align_fail & lane_enable), |(lane_events.checksum_fail & lane_enable),
    |(lane_events.frame_fail & lane_enable), |(lane_events.symbol_fail & lane_enable)};
  property p_reserved; rd_sum |=> reg_rvalid && reg_rdata[4] == 1'b0; endproperty
  a_reserved: assert property (p_reserved) else $error("summary bit 4 not zero");
  property p_live; rd_sum |=> reg_rdata[3:0] == $past(fails, 2); endproperty
  a_live: assert property (p_live) else $error("sync failure flags wrong");
  property p_thresh;
    (reg_req.rd_en && reg_req.addr == ADDR_THRESHOLD && $past(reg_req.wr_en && reg_req.addr == ADDR_THRESHOLD))
      |=> reg_rdata == $past(reg_req.wdata, 2);
  endproperty
  a_thresh: assert property (p_thresh) else $error("threshold readback wrong");
  property p_clear; error_count_clear |-> ##2 !sync_request_output; endproperty
  a_clear: assert property (p_clear) else $error("sync stays after count clear");
  property p_gate; rd_sel |=> !reg_rdata[4] || reg_rdata[3]; endproperty
  a_gate: assert property (p_gate) else $error("latch set while disabled");
  property p_latch_irq; reg_rvalid && $past(rd_sel) && reg_rdata[4] |-> !irq_n; endproperty
  a_latch_irq: assert property (p_latch_irq) else $error("latched mismatch without irq");
  property p_rise;
    rd_sel && !$past(reg_req.wr_en) && $past(mism) && !$past(mism, 2) |=> reg_rdata[4] == reg_rdata[3];
  endproperty
  a_rise: assert property (p_rise) else $error("mismatch rise not latched");
  property p_w1c;
    (reg_req.wr_en && reg_req.addr == ADDR_SELECT && reg_req.wdata[4] && !mism) ##1 (rd_sel && !mism)
      |=> !reg_rdata[4];
  endproperty
  a_w1c: assert property (p_w1c) else $error("latch not cleared by write one");
  c_sync: cover property ($rose(sync_request_output));
  c_irq: cover property ($fell(irq_n));
  c_latch: cover property (reg_rvalid && reg_rdata[4]);
endmodule // sler_props
bind sler_top sler_props #(.LANES(LANES)) sler_props_inst (.core_clk(core_clk), .sys_rst(sys_rst),
  .lane_events(lane_events), .lane_enable(lane_enable), .error_count_clear(error_count_clear),
  .rx_link_config(rx_link_config), .local_link_config(local_link_config), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sync_request_output(sync_request_output),
  .irq_n(irq_n));

// >>> verif/sler_top_tb.sv
// self-checking bench for the error summary block
`timescale 1ns/100ps
module sler_top_tb import sler_pkg::*;;
  logic core_clk = 0;
  logic sys_rst = 1;
  logic [7:0] lane_enable = 8'hff;
  logic error_count_clear = 0;
  logic [CFG_BITS-1:0] local_link_config = {CFG_BYTES{8'h5a}};
  sler_req_type reg_req = '0;
  logic [6:0] kind = '0;
  logic cfg_bad = 0;
  sler_lane_type lane_events;
  logic [CFG_BITS-1:0] rx_link_config;
  logic [7:0] reg_rdata;
  logic reg_rvalid, sync_request_output, irq_n;
  int n_errors = 0;
  int tests_run = 0;
  // 100 MHz clock
  always #5 core_clk = ~core_clk;
  sler_top sler_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .lane_events(lane_events),
    .lane_enable(lane_enable), .error_count_clear(error_count_clear),
    .rx_link_config(rx_link_config), .local_link_config(local_link_config), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sync_request_output(sync_request_output), .irq_n(irq_n));
  sler_lane_model sler_lane_model_inst (.kind(kind), .cfg_bad(cfg_bad),
    .local_link_config(local_link_config), .lane_events(lane_events),
    .rx_link_config(rx_link_config));
  task automatic print_verdict();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // idle the port, then wait n cycles
  task automatic tick(int n);
    reg_req = '0;
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(logic [12:0] a, logic [7:0] d);
    reg_req = '{1'b1, 1'b0, a, d};
    @(negedge core_clk);
  endtask
  task automatic rd(logic [12:0] a, logic [7:0] e);
    reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge core_clk);
    chk("rvalid", 8'h01, {7'h00, reg_rvalid});
    chk("rdata", e, reg_rdata);
  endtask
  // watchdog
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (5) @(negedge core_clk);
    sys_rst = 0;
    rd(ADDR_SUMMARY, 8'h00);
    rd(ADDR_SELECT, 8'h08);
    rd(ADDR_THRESHOLD, 8'hff);
    rd(13'h047d, 8'h00);
    wr(ADDR_SUMMARY, 8'hff);
    rd(ADDR_SUMMARY, 8'h00);
    // each sync failure level shows live and pulls irq low
    for (int j = 0; j < 4; j++) begin
      kind = 7'h01 << j;
      tick(2);
      rd(ADDR_SUMMARY, 8'h01 << j);
      chk("irq_n", 8'h00, irq_n);
      kind = '0;
      tick(3);
      chk("irq_n", 8'h01, irq_n);
    end
    wr(ADDR_THRESHOLD, 8'h02);
    rd(ADDR_THRESHOLD, 8'h02);
    // errors on a disabled lane are not summarised
    lane_enable = 8'hfe;
    kind = 7'h40;
    tick(2);
    kind = '0;
    tick(3);
    rd(ADDR_SUMMARY, 8'h00);
    lane_enable = 8'hff;
    // counted classes, first without then with their sync select
    for (int k = 0; k < 6; k++) begin
      wr(ADDR_SELECT, 8'h08 | (k > 2 ? 8'h80 >> (k % 3) : 8'h00));
      repeat (2) begin
        chk("sync", 8'h00, sync_request_output);
        kind = 7'h40 >> (k % 3);
        tick(1);
        kind = '0;
        tick(3);
      end
      chk("sync", k > 2, sync_request_output);
      rd(ADDR_SUMMARY, 8'h80 >> (k % 3));
      chk("irq_n", 8'h00, irq_n);
      error_count_clear = 1;
      tick(1);
      error_count_clear = 0;
      tick(3);
      chk("sync", 8'h00, sync_request_output);
    end
    // configuration mismatch latch, sticky, write-one clear, disable
    wr(ADDR_SELECT, 8'h08);
    cfg_bad = 1;
    tick(1);
    rd(ADDR_SELECT, 8'h18);
    chk("irq_n", 8'h00, irq_n);
    cfg_bad = 0;
    tick(2);
    rd(ADDR_SELECT, 8'h18);
    wr(ADDR_SELECT, 8'h18);
    rd(ADDR_SELECT, 8'h08);
    chk("irq_n", 8'h01, irq_n);
    wr(ADDR_SELECT, 8'h00);
    cfg_bad = 1;
    tick(3);
    rd(ADDR_SELECT, 8'h00);
    chk("irq_n", 8'h01, irq_n);
    // latch a mismatch, then disable: the latch must drop with the enable
    cfg_bad = 0;
    wr(ADDR_SELECT, 8'h08);
    cfg_bad = 1;
    tick(1);
    wr(ADDR_SELECT, 8'h00);
    rd(ADDR_SELECT, 8'h00);
    print_verdict();
  end
endmodule // sler_top_tb
